// File: logic/peiu_pkg.sv
// package: register map, field positions and reset values of the event interrupt unit
package peiu_pkg;
  localparam int unsigned ADDR_W = 12;
  // printed offsets are not multiples of four: kept as indices, byte address is four times
  localparam logic [7:0] IDX_INT_CONTROL   = 8'h11;
  localparam logic [7:0] IDX_INT_STATUS_EN = 8'h12;
  localparam logic [7:0] IDX_FALSE_CARRIER = 8'h14;
  localparam logic [7:0] IDX_RX_ERROR      = 8'h15;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h20;
  localparam logic [7:0] IDX_IRQ_ENABLE    = 8'h21;
  localparam logic [7:0] IDX_IRQ_CLEAR     = 8'h22;
  localparam int unsigned CTL_OE_BIT    = 0;
  localparam int unsigned CTL_GIE_BIT   = 1;
  localparam int unsigned CTL_TEST_BIT  = 2;
  localparam int unsigned NUM_SRC       = 7;
  localparam int unsigned PEND_LSB      = 8;
  localparam int unsigned EN_LSB        = 0;
  // source order, msb first: energy, link, speed, duplex, autoneg, false carrier, rx error
  localparam int unsigned SRC_FC_HALF   = 1;
  localparam int unsigned SRC_RX_HALF   = 0;
  localparam int unsigned CNT_W         = 8;
  localparam logic [2:0]  CTL_RESET     = 3'h0;
  localparam logic [6:0]  EN_RESET      = 7'h00;
  localparam logic [7:0]  CNT_RESET     = 8'h00;
  // system interrupt status bits
  localparam int unsigned SYS_PEND_BIT  = 0;
  localparam int unsigned SYS_TEST_BIT  = 1;
  localparam int unsigned SYS_W         = 2;
endpackage : peiu_pkg

// File: logic/peiu_sat_counter.sv
// saturating clear-on-read event counter with half-full event
`timescale 1ns/1ps
module peiu_sat_counter
#(
  parameter int unsigned WIDTH = 8
)
(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             inc,
  input  wire logic             clear,
  output logic [WIDTH-1:0]      count,
  output logic                  half_evt
);
  if (WIDTH < 2)
  begin : g_bad_width
    $error("counter width must be at least 2");
  end

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  wire              at_max  = &count_r;
  wire              do_inc  = inc && !at_max;

  // saturate at all ones; a read clears, an increment in the same cycle survives
  assign count_nxt = clear ? (inc ? WIDTH'(1) : '0) : (do_inc ? count_r + WIDTH'(1) : count_r);
  assign count     = count_r;
  // one event as the msb rises
  assign half_evt  = ce && count_nxt[WIDTH-1] && !count_r[WIDTH-1];

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      count_r <= '0;
    else if (ce)
      count_r <= count_nxt;
  end
endmodule : peiu_sat_counter

// File: logic/peiu_top.sv
// phy event interrupt unit: control, status/enable, counters, apb slave
// What this block does
// - Seven interrupt sources: energy, link, speed, duplex, autoneg, two counters half-full.
// - Test bit 2 of control keeps forcing interrupt until cleared.
// - Global enable bit 1 gates all event interrupts.
// - Bit 0 set drives shared pin as interrupt output, else power-down input.
// - Pending bit set when its event occurred since last status read.
// - Pending recorded even with individual or global enable cleared.
// - Interrupt needs event, its enable, and global controls set.
// - Pending flags at status bits 14:8, cleared by the read returning them.
// - Enables at bits 6:0, same order, reset to zero.
// - Reserved bits ignore writes and read zero.
// - False carrier counter: 8 bits at 7:0, one count per event.
// - False carrier counter saturates at all ones.
// - False carrier counter read-only, resets zero, cleared by read.
// - False carrier counter half-full sets pending bit 9, enable bit 1.
// - Receive error counter saturating, clear on read, once per carrier, no collision.
// - Phy status interrupt-pending bit high while any pending, cleared by status read.
`timescale 1ns/1ps
module peiu_top
  import peiu_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  input  wire logic [peiu_pkg::ADDR_W-1:0] paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        energy_change,
  input  wire logic                        link_change,
  input  wire logic                        speed_change,
  input  wire logic                        duplex_change,
  input  wire logic                        autoneg_done,
  input  wire logic                        false_carrier_evt,
  input  wire logic                        rx_error_evt,
  input  wire logic                        collision,
  input  wire logic                        carrier_start,
  input  wire logic                        powerdown_irq_pin_i,
  output logic                             powerdown_irq_pin_o,
  output logic                             powerdown_irq_pin_oe,
  output logic                             powerdown_req,
  output logic                             phy_status_irq_pending,
  output logic                             irq
);
  import peiu_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
  endfunction : hit

  // count as it stands after this cycle, so a read returns an event landing with it
  function automatic logic [CNT_W-1:0] sat_peek(input logic [CNT_W-1:0] c, input logic inc);
    sat_peek = (inc && !(&c)) ? c + CNT_W'(1) : c;
  endfunction : sat_peek

  logic [2:0]         ctl_r;
  logic [NUM_SRC-1:0] en_r;
  logic [NUM_SRC-1:0] pend_r;
  logic [NUM_SRC-1:0] pend_nxt;
  logic [SYS_W-1:0]   sys_stat_r;
  logic [SYS_W-1:0]   sys_stat_nxt;
  logic [SYS_W-1:0]   sys_en_r;
  logic [31:0]        prdata_r;
  logic               irq_r;
  logic               rx_counted_r;

  // apb: zero wait states, answer in first access cycle
  wire  setup_ok   = psel && !penable;
  wire  access     = psel && penable && clk_en;
  wire  wr         = access && pwrite;
  wire  rd         = access && !pwrite;
  wire  sel_ctl    = hit(paddr, IDX_INT_CONTROL);
  wire  sel_se     = hit(paddr, IDX_INT_STATUS_EN);
  wire  sel_fc     = hit(paddr, IDX_FALSE_CARRIER);
  wire  sel_rx     = hit(paddr, IDX_RX_ERROR);
  wire  sel_sst    = hit(paddr, IDX_IRQ_STATUS);
  wire  sel_sen    = hit(paddr, IDX_IRQ_ENABLE);
  wire  sel_scl    = hit(paddr, IDX_IRQ_CLEAR);
  wire  mapped     = sel_ctl | sel_se | sel_fc | sel_rx | sel_sst | sel_sen | sel_scl;
  wire  lo_lanes   = pstrb[0];
  wire  hi_lanes   = pstrb[1];
  wire  rd_status  = rd && sel_se;
  wire  rd_fc      = rd && sel_fc;
  wire  rd_rx      = rd && sel_rx;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  logic [CNT_W-1:0] fc_count;
  logic [CNT_W-1:0] rx_count;
  logic             fc_half;
  logic             rx_half;

  peiu_sat_counter #(.WIDTH(CNT_W)) u_fc_cnt
  (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .ce       (clk_en),
    .inc      (false_carrier_evt),
    .clear    (rd_fc),
    .count    (fc_count),
    .half_evt (fc_half)
  );

  // at most one count per carrier event, none under collision
  wire rx_inc = rx_error_evt && !collision && (!rx_counted_r || carrier_start);

  peiu_sat_counter #(.WIDTH(CNT_W)) u_rx_cnt
  (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .ce       (clk_en),
    .inc      (rx_inc),
    .clear    (rd_rx),
    .count    (rx_count),
    .half_evt (rx_half)
  );

  wire [NUM_SRC-1:0] evt = {energy_change, link_change, speed_change, duplex_change,
                            autoneg_done, fc_half, rx_half};

  // pending set regardless of enables; set wins over read clear
  assign pend_nxt = (rd_status ? '0 : pend_r) | evt;

  wire gie        = ctl_r[CTL_GIE_BIT];
  wire test_force = ctl_r[CTL_TEST_BIT];
  wire any_pend   = |pend_r;
  wire evt_irq    = gie && |(pend_r & en_r);
  wire phy_irq    = evt_irq || test_force;

  wire [SYS_W-1:0] sys_evt = {test_force, evt_irq};
  wire [SYS_W-1:0] sys_clr = (wr && sel_scl && lo_lanes) ? pwdata[SYS_W-1:0] : '0;
  assign sys_stat_nxt = (sys_stat_r & ~sys_clr) | sys_evt;

  wire [15:0] rd_ctl = {13'h0000, ctl_r};
  // read data taken in setup: include events of that cycle, the access clears them
  wire [15:0] rd_se  = {1'b0, pend_nxt, 1'b0, en_r};
  wire [15:0] rd_fcw = {8'h00, sat_peek(fc_count, false_carrier_evt)};
  wire [15:0] rd_rxw = {8'h00, sat_peek(rx_count, rx_inc)};
  wire [31:0] rd_mux = sel_ctl ? {16'h0000, rd_ctl} :
                       sel_se  ? {16'h0000, rd_se}  :
                       sel_fc  ? {16'h0000, rd_fcw} :
                       sel_rx  ? {16'h0000, rd_rxw} :
                       sel_sst ? {30'h00000000, sys_stat_r} :
                       sel_sen ? {30'h00000000, sys_en_r} : 32'h00000000;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ctl_r <= CTL_RESET;
      en_r  <= EN_RESET;
    end
    else if (wr && lo_lanes)
    begin
      if (sel_ctl)
        ctl_r <= pwdata[2:0];
      if (sel_se)
        en_r <= pwdata[EN_LSB +: NUM_SRC];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pend_r     <= '0;
      sys_stat_r <= '0;
      sys_en_r   <= '0;
    end
    else if (clk_en)
    begin
      pend_r     <= pend_nxt;
      sys_stat_r <= sys_stat_nxt;
      if (wr && sel_sen && lo_lanes)
        sys_en_r <= pwdata[SYS_W-1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rx_counted_r <= 1'b0;
    else if (clk_en)
    begin
      if (carrier_start)
        rx_counted_r <= rx_inc;
      else if (rx_inc)
        rx_counted_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      prdata_r <= 32'h00000000;
      irq_r    <= 1'b0;
    end
    else if (clk_en)
    begin
      if (setup_ok && !pwrite)
        prdata_r <= rd_mux;
      irq_r <= |(sys_stat_nxt & sys_en_r);
    end
  end

  assign prdata = prdata_r;
  assign irq    = irq_r;

  // shared pin: interrupt output active low when enabled, else power-down input
  assign powerdown_irq_pin_oe   = ctl_r[CTL_OE_BIT];
  assign powerdown_irq_pin_o    = !phy_irq;
  assign powerdown_req          = !ctl_r[CTL_OE_BIT] && !powerdown_irq_pin_i;
  assign phy_status_irq_pending = any_pend;

  upper_lane_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr && sel_ctl && hi_lanes && !lo_lanes) |=> $stable(ctl_r)) else $error("upper lane wrote");

  pend_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && evt[6]) |=> pend_r[6]) else $error("energy event lost");

  pend_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rd_status && evt == '0) |=> pend_r == '0) else $error("status read did not clear");

  test_force_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    test_force |-> !powerdown_irq_pin_o) else $error("test bit not forcing");

  gie_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!gie && !test_force) |-> powerdown_irq_pin_o) else $error("event irq without global");

  fc_sat_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fc_count == 8'hFF && !rd_fc) |=> fc_count == 8'hFF) else $error("counter wrapped");

  fc_clr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rd_fc && !false_carrier_evt) |=> fc_count == 8'h00) else $error("counter not cleared");

  fc_half_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && !fc_count[7] && $past(clk_en) && fc_half) |=> pend_r[SRC_FC_HALF])
    else $error("half-full flag missing");

  pend_stat_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    phy_status_irq_pending == (pend_r != '0)) else $error("phy status pending wrong");

  pin_dir_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(ctl_r[CTL_OE_BIT]) |-> powerdown_irq_pin_oe && !powerdown_req)
    else $error("pin direction wrong");

  rsv_ctl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && setup_ok && !pwrite && sel_ctl) |=> prdata[31:3] == '0)
    else $error("control reserved bits set");

  rsv_se_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && setup_ok && !pwrite && sel_se) |=> (prdata[31:16] == '0 && !prdata[15] && !prdata[7]))
    else $error("status reserved bits set");

  fc_upper_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && setup_ok && !pwrite && sel_fc) |=> prdata[31:8] == '0)
    else $error("counter upper bits set");

  fc_step_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && false_carrier_evt && !rd_fc && fc_count != 8'hFF) |=> fc_count == $past(fc_count) + 8'h01)
    else $error("counter missed a step");

  fc_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && !false_carrier_evt && !rd_fc) |=> $stable(fc_count))
    else $error("counter moved without event");

  rx_once_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && rx_inc) |=> (!rx_inc || carrier_start))
    else $error("rx counted twice per carrier");

  rx_col_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && collision && !rd_rx) |=> $stable(rx_count))
    else $error("rx counted under collision");

  rx_half_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && rx_half) |=> pend_r[SRC_RX_HALF])
    else $error("rx half-full flag missing");

  fc_edge_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    fc_half |-> !fc_count[7])
    else $error("half-full event repeated");

  pend_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && !rd_status) |=> (pend_r & $past(pend_r)) == $past(pend_r))
    else $error("pending lost without read");

  en_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr && sel_se && lo_lanes) |=> en_r == $past(pwdata[6:0]))
    else $error("enable write lost");

  link_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && evt[5]) |=> pend_r[5])
    else $error("link event lost");

  speed_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && evt[4]) |=> pend_r[4])
    else $error("speed event lost");

  duplex_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && evt[3]) |=> pend_r[3])
    else $error("duplex event lost");

  autoneg_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && evt[2]) |=> pend_r[2])
    else $error("autoneg event lost");

  evt_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (gie && (pend_r & en_r) != '0) |-> !powerdown_irq_pin_o)
    else $error("enabled event without irq");

  en_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!test_force && (pend_r & en_r) == '0) |-> powerdown_irq_pin_o)
    else $error("irq without enabled event");

  pdn_input_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !ctl_r[CTL_OE_BIT] |-> powerdown_req == !powerdown_irq_pin_i)
    else $error("power-down input ignored");

  oe_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctl_r[CTL_OE_BIT] |-> !powerdown_req)
    else $error("power-down while driving");

  test_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($fell(test_force) && !gie) |-> powerdown_irq_pin_o)
    else $error("irq held after test bit");

  stat_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rd_status && evt == '0) |=> !phy_status_irq_pending)
    else $error("phy pending not cleared");

  ctl_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr && sel_ctl && lo_lanes) |=> ctl_r == $past(pwdata[2:0]))
    else $error("control write lost");
endmodule : peiu_top

// File: sim/peiu_mgmt_model.sv
// management controller model: apb master transfers into the event interrupt unit
`timescale 1ns/1ps
module peiu_mgmt_model
  import peiu_pkg::*;
(
  input  wire logic                        clk_sys,
  output logic      [peiu_pkg::ADDR_W-1:0] paddr,
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic      [31:0]                 pwdata,
  output logic      [3:0]                  pstrb,
  input  wire logic [31:0]                 prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr
);
  logic last_err;
  initial
  begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    last_err = 1'b0;
  end
  // one idle edge first, so back-to-back calls never drive twice in one step
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hF;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : peiu_mgmt_model

// File: sim/tb_peiu_top.sv
// testbench: event interrupt unit driven through the management model
`timescale 1ns/1ps
module tb_peiu_top;
  import peiu_pkg::*;
  logic        clk_sys;
  logic        resetn = 1'b0;
  logic [4:0]  ev     = 5'h00;
  logic        fce    = 1'b0;
  logic        rxe    = 1'b0;
  logic        col    = 1'b0;
  logic        cs     = 1'b0;
  logic        pd_drv = 1'b0;
  logic        ce     = 1'b1;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_o;
  logic        pin_oe;
  logic        pd_req;
  logic        phy_pend;
  logic        irq;
  wire         pin_w = pin_oe ? pin_o : pd_drv;
  int          err_count   = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  logic [4:0]  row_ev [6]  = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h11};
  logic [15:0] row_st [6]  = '{16'h407F, 16'h207F, 16'h107F, 16'h087F, 16'h047F, 16'h447F};
  peiu_top peiu_top_inst (.clk_sys(clk_sys), .resetn(resetn), .clk_en(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .energy_change(ev[4]),
    .link_change(ev[3]), .speed_change(ev[2]), .duplex_change(ev[1]), .autoneg_done(ev[0]),
    .false_carrier_evt(fce), .rx_error_evt(rxe), .collision(col), .carrier_start(cs),
    .powerdown_irq_pin_i(pin_w), .powerdown_irq_pin_o(pin_o), .powerdown_irq_pin_oe(pin_oe),
    .powerdown_req(pd_req), .phy_status_irq_pending(phy_pend), .irq(irq));
  peiu_mgmt_model peiu_mgmt_model_inst (.clk_sys(clk_sys), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask : check
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    peiu_mgmt_model_inst.xfer(1'b0, a, 32'h0, d);
    check(d, exp);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    peiu_mgmt_model_inst.xfer(1'b1, a, wd, d);
  endtask : wr
  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask : settle
  task automatic pulse_ev(input logic [4:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 5'h00;
  endtask : pulse_ev
  task automatic fc_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      fce <= 1'b1;
      @(posedge clk_sys);
      fce <= 1'b0;
    end
  endtask : fc_pulses
  // two error cycles inside one carrier, collision optionally present
  task automatic carrier(input logic c);
    @(posedge clk_sys);
    cs <= 1'b1;
    col <= c;
    @(posedge clk_sys);
    cs <= 1'b0;
    rxe <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rxe <= 1'b0;
    col <= 1'b0;
  endtask : carrier
  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(12'h044, 32'h0);
    rd(12'h048, 32'h0);
    rd(12'h050, 32'h0);
    check({30'h0, pin_oe, pd_req}, 32'h1);
    $display("test reset done");
    wr(12'h084, 32'h3);
    wr(12'h044, 32'hFFFF);
    rd(12'h044, 32'h7);
    settle();
    check({30'h0, pin_o, irq}, 32'h1);
    rd(12'h080, 32'h2);
    wr(12'h044, 32'h3);
    wr(12'h088, 32'h3);
    settle();
    check({29'h0, pin_oe, pin_o, irq}, 32'h6);
    wr(12'h048, 32'hFFFF);
    rd(12'h048, 32'h7F);
    wr(12'h0FC, 32'h1);
    check({31'h0, peiu_mgmt_model_inst.last_err}, 32'h1);
    wr(12'h084, 32'h1);
    $display("test control done");
    for (int i = 0; i < 6; i++)
    begin
      pulse_ev(row_ev[i]);
      settle();
      check({30'h0, pin_o, phy_pend}, 32'h1);
      rd(12'h048, {16'h0, row_st[i]});
      settle();
      check({30'h0, pin_o, phy_pend}, 32'h2);
      rd(12'h048, 32'h7F);
    end
    check({31'h0, irq}, 32'h1);
    wr(12'h088, 32'h1);
    settle();
    check({31'h0, irq}, 32'h0);
    $display("test rows done");
    wr(12'h044, 32'h1);
    pulse_ev(5'h08);
    settle();
    check({31'h0, pin_o}, 32'h1);
    rd(12'h048, 32'h207F);
    wr(12'h044, 32'h3);
    wr(12'h048, 32'h0);
    pulse_ev(5'h04);
    settle();
    check({31'h0, pin_o}, 32'h1);
    rd(12'h048, 32'h1000);
    wr(12'h048, 32'h7F);
    $display("test gating done");
    fc_pulses(5);
    rd(12'h050, 32'h5);
    fc_pulses(127);
    rd(12'h048, 32'h7F);
    fc_pulses(1);
    settle();
    check({31'h0, pin_o}, 32'h0);
    rd(12'h048, 32'h27F);
    fc_pulses(200);
    rd(12'h050, 32'hFF);
    rd(12'h050, 32'h0);
    wr(12'h050, 32'h55);
    rd(12'h050, 32'h0);
    rd(12'h048, 32'h7F);
    $display("test false carrier done");
    repeat (127) carrier(1'b0);
    carrier(1'b1);
    rd(12'h048, 32'h7F);
    carrier(1'b0);
    rd(12'h048, 32'h17F);
    rd(12'h054, 32'h80);
    $display("test rx error done");
    ce <= 1'b0;
    wr(12'h044, 32'h0);
    fc_pulses(3);
    ce <= 1'b1;
    rd(12'h044, 32'h3);
    rd(12'h050, 32'h0);
    $display("test freeze done");
    wr(12'h044, 32'h0);
    pd_drv <= 1'b1;
    settle();
    check({30'h0, pin_oe, pd_req}, 32'h0);
    $display("test pin done");
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(12'h048, 32'h0);
    rd(12'h084, 32'h0);
    check({30'h0, pin_oe, pd_req}, 32'h0);
    $display("test second reset done");
    final_report();
  end
endmodule : tb_peiu_top
